// file: lfc_pkg.sv
package lfc_pkg;

  localparam logic [3:0] WRITE_BITS   = 4'h8;
  localparam logic [1:0] RING_CONFIRM = 2'h2;

  typedef struct packed {
    logic ilimHi;
    logic ilimLo;
    logic boostBattery;
    logic polarity;
    logic meterLevel;
    logic ringSelect;
    logic injectTiming;
    logic impedance;
  } lfc_cmd_t;

  typedef struct packed {
    logic thermal;
    logic lowLineVoltage;
    logic currentLimiter;
    logic groundKey;
    logic hook;
  } lfc_status_t;

  typedef struct packed {
    logic ifaceClock;
    logic dataIn;
    logic dirSel;
    logic csN;
    logic csMode;
    logic strap;
    logic hook;
    logic groundKeyLow;
    logic curLimit;
    logic lowVolt;
    logic thermal;
    logic loopClosed;
    logic ringPhase;
  } lfc_pins_t;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'h0,
    PH_WRITE = 2'h1,
    PH_READ  = 2'h2
  } lfc_phase_t;

  typedef struct packed {
    lfc_pins_t   syncA;
    lfc_pins_t   syncB;
    logic        clkPrev;
    logic        ringPrev;
    logic        csSelPrev;
    lfc_phase_t  phase;
    logic [7:0]  shift;
    logic [3:0]  bitCnt;
    lfc_cmd_t    cmd;
    logic [4:0]  outShift;
    logic [1:0]  ringCnt;
    logic        ringTrip;
    lfc_status_t status;
    logic        dataOut;
    logic        dataOe;
    logic        csOut;
    logic        csOe;
    logic        powerDown;
    logic        standby;
    logic        lowLimitStandby;
    logic        ringActive;
    logic        meterActive;
  } lfc_state_t;

  // chip select idles high so a reset never looks like a selected frame
  localparam lfc_pins_t PINS_IDLE = 13'h0200;
  localparam lfc_cmd_t  CMD_RESET = 8'h00;
  localparam logic      PAR_ILIM_HI = 1'b1;
  localparam logic      PAR_ILIM_LO = 1'b0;

  localparam lfc_state_t STATE_RESET = '{
    syncA: PINS_IDLE, syncB: PINS_IDLE, phase: PH_IDLE, cmd: CMD_RESET,
    default: '0};

endpackage

// file: lfc_line_feed_control.sv
`timescale 1ns/1ps

// Overview of operation
// - write frame shifts exactly eight command bits
// - command bit sampled on interface clock rise
// - chip select rise commits shifted command word
// - read frame drives up to five status bits
// - bit0 chooses high impedance or conversation
// - bit1 turns injection timing on or off
// - bit2 selects metering or ring injection
// - bit3 selects metering amplitude low or high
// - bit4 polarity reverse, bit5 boosted battery
// - bits6/7 select one of four current limits
// - mode pin turns chip select into alarm
// - status bit0 reports off hook
// - status bit1 reports ground key current low
// - status bit2 limiter only in conversation
// - status bit3 reports line below half battery
// - status bit4 flags thermal overload
// - parallel strap bypasses registers, pins act directly
// - parallel pins map bits0-2, rest fixed 30mA
// - bits0 and 1 low give standby
// - all-zero command is power-down, no hook sensing
// - ring trip confirmed after two closed periods
module lfc_line_feed_control (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // control wires from the card controller
  input  wire logic              ifaceClock,
  input  wire logic              bidirDataIn,
  output logic                   bidirDataOut,
  output logic                   bidirDataOe,
  input  wire logic              directionSelect,
  input  wire logic              chipSelectNIn,
  output logic                   chipSelectNOut,
  output logic                   chipSelectNOe,
  input  wire logic              csModeSelect,
  input  wire logic              parallelStrap,
  // line sensing from the analog side
  input  wire logic              lineOffHook,
  input  wire logic              groundKeyLow,
  input  wire logic              currentLimiting,
  input  wire logic              lowLineVoltage,
  input  wire logic              thermalOverload,
  input  wire logic              loopClosed,
  input  wire logic              ringPhase,
  // line feeding controls toward the analog side
  output lfc_pkg::lfc_cmd_t      lineCmd,
  output lfc_pkg::lfc_status_t   lineStatus,
  output logic                   powerDown,
  output logic                   standbyState,
  output logic                   lowLimitStandby,
  output logic                   ringActive,
  output logic                   meteringPulse
);

  lfc_pkg::lfc_state_t q;
  lfc_pkg::lfc_state_t d;
  lfc_pkg::lfc_pins_t  pinsIn;
  lfc_pkg::lfc_cmd_t   parCmd;
  logic                serial;
  logic                csSel;
  logic                clkRise;
  logic                ringRise;
  logic                ringMode;
  logic [2:0]          wrIdx;

  // ring mode needs high impedance with ring injection chosen
  function automatic logic ringSel(input lfc_pkg::lfc_cmd_t c);
    return ~c.impedance & c.ringSelect;
  endfunction

  assign pinsIn = {ifaceClock, bidirDataIn, directionSelect, chipSelectNIn,
                   csModeSelect, parallelStrap, lineOffHook, groundKeyLow,
                   currentLimiting, lowLineVoltage, thermalOverload,
                   loopClosed, ringPhase};

  always_comb begin
    d        = q;
    d.syncA  = pinsIn;
    d.syncB  = q.syncA;
    serial   = ~q.syncB.strap;
    // with the mode pin high the chip select pin is ours, never a select
    csSel    = serial & ~q.syncB.csMode & ~q.syncB.csN;
    clkRise  = q.syncB.ifaceClock & ~q.clkPrev;
    ringRise = q.syncB.ringPhase & ~q.ringPrev;
    wrIdx    = q.bitCnt[2:0];
    d.clkPrev   = q.syncB.ifaceClock;
    d.ringPrev  = q.syncB.ringPhase;
    d.csSelPrev = csSel;

    parCmd              = lfc_pkg::CMD_RESET;
    parCmd.impedance    = q.syncB.dirSel;
    parCmd.injectTiming = q.syncB.csMode;
    parCmd.ringSelect   = q.syncB.ifaceClock;
    parCmd.ilimHi       = lfc_pkg::PAR_ILIM_HI;
    parCmd.ilimLo       = lfc_pkg::PAR_ILIM_LO;

    if (!serial) begin
      d.phase = lfc_pkg::PH_IDLE;
      d.cmd   = parCmd;
    end else begin
      case (q.phase)
        lfc_pkg::PH_IDLE: begin
          if (csSel && !q.csSelPrev) begin
            if (q.syncB.dirSel) begin
              d.phase    = lfc_pkg::PH_READ;
              d.outShift = q.status;
            end else begin
              d.phase  = lfc_pkg::PH_WRITE;
              d.bitCnt = 4'h0;
            end
          end
        end
        lfc_pkg::PH_WRITE: begin
          if (!csSel) begin
            // a short frame is dropped rather than half applied
            if (q.bitCnt == lfc_pkg::WRITE_BITS) begin
              d.cmd = lfc_pkg::lfc_cmd_t'(q.shift);
            end
            d.phase = lfc_pkg::PH_IDLE;
          end else if (q.syncB.dirSel) begin
            d.phase = lfc_pkg::PH_IDLE;
          end else if (clkRise && q.bitCnt < lfc_pkg::WRITE_BITS) begin
            d.shift[wrIdx] = q.syncB.dataIn;
            d.bitCnt       = q.bitCnt + 4'h1;
          end
        end
        lfc_pkg::PH_READ: begin
          if (!csSel) begin
            d.phase = lfc_pkg::PH_IDLE;
          end else if (clkRise) begin
            // zeros fill in once all five bits have gone out
            d.outShift = {1'b0, q.outShift[4:1]};
          end
        end
        default: d.phase = lfc_pkg::PH_IDLE;
      endcase
    end

    // ring trip confirmation, cleared whenever the command word changes
    ringMode = ringSel(q.cmd);
    if (d.cmd != q.cmd) begin
      d.ringTrip = 1'b0;
      d.ringCnt  = 2'h0;
    end else if (ringMode && q.cmd.injectTiming && !q.ringTrip) begin
      if (!q.syncB.loopClosed) begin
        d.ringCnt = 2'h0;
      end else if (ringRise) begin
        if (q.ringCnt == lfc_pkg::RING_CONFIRM - 2'h1) begin
          d.ringTrip = 1'b1;
        end else begin
          d.ringCnt = q.ringCnt + 2'h1;
        end
      end
    end

    // hook reads only the confirmed trip while ringing
    if (ringMode) begin
      d.status.hook = q.ringTrip;
    end else begin
      d.status.hook = q.syncB.hook & (q.cmd != lfc_pkg::CMD_RESET);
    end
    d.status.groundKey      = q.syncB.groundKeyLow;
    d.status.currentLimiter = q.syncB.curLimit & q.cmd.impedance;
    d.status.lowLineVoltage = q.syncB.lowVolt;
    d.status.thermal        = q.syncB.thermal;

    // pin drive
    d.dataOe  = serial & csSel & q.syncB.dirSel
                & (d.phase == lfc_pkg::PH_READ);
    d.dataOut = d.dataOe & d.outShift[0];
    d.csOe    = q.syncB.strap | q.syncB.csMode;
    d.csOut   = d.status.hook | (serial & d.status.groundKey);
    if (!serial) begin
      d.dataOe  = 1'b1;
      d.dataOut = ~d.status.groundKey;
    end

    // decoded line states for the feeding stage
    d.powerDown       = (d.cmd == lfc_pkg::CMD_RESET);
    d.standby         = ~d.cmd.impedance & ~d.cmd.injectTiming;
    d.lowLimitStandby = d.standby & (d.cmd.ilimHi | d.cmd.ilimLo);
    d.ringActive      = ringSel(d.cmd)
                        & d.cmd.injectTiming & ~d.ringTrip
                        & ~q.syncB.loopClosed;
    d.meterActive     = d.cmd.impedance & d.cmd.injectTiming
                        & ~d.cmd.ringSelect;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= lfc_pkg::STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // level, polarity, battery and limit bits pass straight through
  assign lineCmd         = q.cmd;
  assign lineStatus      = q.status;
  assign bidirDataOut    = q.dataOut;
  assign bidirDataOe     = q.dataOe;
  assign chipSelectNOut  = q.csOut;
  assign chipSelectNOe   = q.csOe;
  assign powerDown       = q.powerDown;
  assign standbyState    = q.standby;
  assign lowLimitStandby = q.lowLimitStandby;
  assign ringActive      = q.ringActive;
  assign meteringPulse   = q.meterActive;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_shift_bit: assert property (
    (q.phase == lfc_pkg::PH_WRITE) && csSel && !q.syncB.dirSel && clkRise
    && (q.bitCnt < lfc_pkg::WRITE_BITS)
    |=> q.shift[$past(wrIdx)] == $past(q.syncB.dataIn))
    else $error("command bit not sampled");

  chk_commit_word: assert property (
    (q.phase == lfc_pkg::PH_WRITE) && !csSel && serial
    && (q.bitCnt == lfc_pkg::WRITE_BITS)
    |=> q.cmd == $past(q.shift)
    ##1 q.powerDown == (q.cmd == lfc_pkg::CMD_RESET))
    else $error("command word not committed");

  chk_short_frame: assert property (
    (q.phase == lfc_pkg::PH_WRITE) && !csSel && serial
    && (q.bitCnt != lfc_pkg::WRITE_BITS)
    |=> $stable(q.cmd))
    else $error("short write frame applied");

  chk_read_first: assert property (
    (q.phase == lfc_pkg::PH_IDLE) && csSel && !q.csSelPrev
    && q.syncB.dirSel ##1 csSel && q.syncB.dirSel
    |=> q.dataOe && (q.dataOut == $past(q.status.hook, 2)))
    else $error("status bit0 not driven on read");

  chk_cs_alarm: assert property (
    serial && q.syncB.csMode
    |=> q.csOe && (q.csOut == (q.status.hook | q.status.groundKey)))
    else $error("chip select alarm wrong");

  chk_limiter_conv: assert property (
    q.status.currentLimiter |-> $past(q.cmd.impedance))
    else $error("limiter flag outside conversation");

  chk_pd_no_hook: assert property (
    (q.cmd == lfc_pkg::CMD_RESET) [*2] |=> !q.status.hook)
    else $error("hook seen in power-down");

  chk_standby: assert property (
    $past(rst_n) && !q.cmd.impedance && !q.cmd.injectTiming
    && $stable(q.cmd)
    |-> q.standby && !q.ringActive && !q.meterActive)
    else $error("standby not entered");

  chk_ring_trip: assert property (
    $rose(q.ringTrip) |-> $past(q.syncB.loopClosed)
    && ($past(q.ringCnt) == lfc_pkg::RING_CONFIRM - 2'h1))
    else $error("ring trip without two periods");

  chk_parallel_map: assert property (
    !serial |=> (q.cmd.impedance == $past(q.syncB.dirSel))
    && q.cmd.ilimHi && !q.cmd.ilimLo && !q.cmd.meterLevel)
    else $error("parallel command mapping wrong");

  chk_parallel_pins: assert property (
    !serial |=> q.dataOe && q.csOe && (q.csOut == q.status.hook)
    && (q.dataOut == !q.status.groundKey))
    else $error("parallel status pins wrong");

  chk_read_shift: assert property (
    (q.phase == lfc_pkg::PH_READ) && csSel && clkRise
    |=> (q.outShift[3:0] == $past(q.outShift[4:1])) && !q.outShift[4])
    else $error("status word not shifted on read");

  chk_read_release: assert property (
    (q.phase == lfc_pkg::PH_READ) && serial && !csSel |=> !q.dataOe)
    else $error("data line still driven after read");

  chk_ground_key: assert property (
    q.status.groundKey == $past(q.syncB.groundKeyLow))
    else $error("ground key status wrong");

  chk_thermal_bit: assert property (
    q.status.thermal == $past(q.syncB.thermal))
    else $error("thermal status wrong");

  chk_ring_active: assert property (
    q.ringActive |-> !q.cmd.impedance && q.cmd.injectTiming
    && q.cmd.ringSelect)
    else $error("ringing outside ring mode");

  chk_meter_active: assert property (
    q.meterActive |-> q.cmd.impedance && q.cmd.injectTiming
    && !q.cmd.ringSelect)
    else $error("metering outside conversation");

  cov_write: cover property (
    (q.phase == lfc_pkg::PH_WRITE) ##1 (q.phase == lfc_pkg::PH_IDLE)
    && (q.cmd != $past(q.cmd)));
  cov_read: cover property (q.dataOe && serial ##[1:400] !q.dataOe);
  cov_ring_trip: cover property ($rose(q.ringTrip));
  cov_parallel: cover property (!serial ##1 q.cmd.ringSelect);

endmodule

// file: lfc_ctrl_model.sv
`timescale 1ns/1ps
module lfc_ctrl_model (
  // clock
  input  wire logic ref_clk,
  // control wires toward the device
  output logic      ifaceClock,
  output logic      dataDrive,
  output logic      dirSel,
  output logic      csN,
  // resolved data line
  input  wire logic dataLine
);
  initial begin
    ifaceClock = 1'b0;
    dataDrive  = 1'b0;
    dirSel     = 1'b0;
    csN        = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // 31-cycle clock keeps runs short; halves stay over three ref_clk
  task automatic frame(input logic rd, input logic [7:0] wr,
                       input int n, output logic [7:0] got);
    got = 8'h00;
    dirSel <= rd;
    csN <= 1'b0;
    tick(8);
    for (int i = 0; i < n; i++) begin
      if (!rd)
        dataDrive <= wr[i];
      tick(15);
      got[i] = dataLine;
      ifaceClock <= 1'b1;
      tick(16);
      ifaceClock <= 1'b0;
    end
    tick(8);
    csN <= 1'b1;
    // a released line must not keep showing the last bit
    dataDrive <= ~dataDrive;
    tick(12);
    dirSel <= 1'b0;
    // let an edge pass so a following frame never re-drives dirSel at once
    tick(1);
  endtask
endmodule

// file: lfc_line_feed_control_bench.sv
`timescale 1ns/1ps
module lfc_line_feed_control_bench;
  logic                 ref_clk = 1'b0;
  logic                 rst_n;
  logic                 csModeSelect;
  logic                 parallelStrap;
  logic [4:0]           lineIn;
  logic                 loopClosed;
  logic                 ringPhase;
  logic                 ifaceClock, dataDrive, dirSel, csN, dataLine;
  logic                 dataOut, dataOe, csOut, csOe;
  lfc_pkg::lfc_cmd_t    lineCmd;
  lfc_pkg::lfc_status_t lineStatus;
  logic                 powerDown, standbyState, lowLimitStandby;
  logic                 ringActive, meteringPulse;
  logic [7:0]           got;
  int                   err_total = 0;
  int                   checked = 0;
  // command, then powerDown, standby, lowLimit, ring, metering
  logic [12:0] rows [11] = '{
    {8'h00, 5'b11000}, {8'h01, 5'b00000}, {8'h03, 5'b00001},
    {8'h0B, 5'b00001}, {8'h07, 5'b00000}, {8'h31, 5'b00000},
    {8'h41, 5'b00000}, {8'h81, 5'b00000},
    {8'hC0, 5'b01100},
    {8'h86, 5'b00010},
    {8'h04, 5'b01000}};
  logic [4:0]  pats [3] = '{5'h15, 5'h0A, 5'h1C};

  always #2 ref_clk = ~ref_clk;
  assign dataLine = dataOe ? dataOut : dataDrive;

  lfc_ctrl_model lfc_ctrl_model_i (
    .ref_clk    (ref_clk),
    .ifaceClock (ifaceClock),
    .dataDrive  (dataDrive),
    .dirSel     (dirSel),
    .csN        (csN),
    .dataLine   (dataLine)
  );

  lfc_line_feed_control lfc_line_feed_control_i (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .ifaceClock      (ifaceClock),
    .bidirDataIn     (dataLine),
    .bidirDataOut    (dataOut),
    .bidirDataOe     (dataOe),
    .directionSelect (dirSel),
    .chipSelectNIn   (csN),
    .chipSelectNOut  (csOut),
    .chipSelectNOe   (csOe),
    .csModeSelect    (csModeSelect),
    .parallelStrap   (parallelStrap),
    .lineOffHook     (lineIn[0]),
    .groundKeyLow    (lineIn[1]),
    .currentLimiting (lineIn[2]),
    .lowLineVoltage  (lineIn[3]),
    .thermalOverload (lineIn[4]),
    .loopClosed      (loopClosed),
    .ringPhase       (ringPhase),
    .lineCmd         (lineCmd),
    .lineStatus      (lineStatus),
    .powerDown       (powerDown),
    .standbyState    (standbyState),
    .lowLimitStandby (lowLimitStandby),
    .ringActive      (ringActive),
    .meteringPulse   (meteringPulse)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ring_period();
    ringPhase <= 1'b1;
    lfc_ctrl_model_i.tick(6);
    ringPhase <= 1'b0;
    lfc_ctrl_model_i.tick(6);
  endtask

  task automatic wrap_up();
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    wrap_up();
  end

  initial begin
    rst_n         <= 1'b0;
    csModeSelect  <= 1'b0;
    parallelStrap <= 1'b0;
    lineIn        <= 5'h00;
    loopClosed    <= 1'b0;
    ringPhase     <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    lfc_ctrl_model_i.tick(6);
    foreach (rows[i]) begin
      lfc_ctrl_model_i.frame(1'b0, rows[i][12:5], 8, got);
      chk(lineCmd, rows[i][12:5]);
      chk({powerDown, standbyState, lowLimitStandby, ringActive,
           meteringPulse}, rows[i][4:0]);
    end
    chk(standbyState, 1'b1);
    // seven clocks only: the word must be dropped
    lfc_ctrl_model_i.frame(1'b0, 8'hFF, 7, got);
    chk(lineCmd, 8'h04);
    lfc_ctrl_model_i.frame(1'b0, 8'h01, 8, got);
    foreach (pats[i]) begin
      lineIn <= pats[i];
      lfc_ctrl_model_i.tick(6);
      chk(lineStatus, pats[i]);
      lfc_ctrl_model_i.frame(1'b1, 8'h00, 5, got);
      chk(got, pats[i]);
    end
    lfc_ctrl_model_i.frame(1'b1, 8'h00, 3, got);
    chk(got, 8'h04);
    // a closure must hold across two ring periods to count as a trip
    lfc_ctrl_model_i.frame(1'b0, 8'h86, 8, got);
    loopClosed <= 1'b1;
    ring_period();
    chk({lineStatus[0], ringActive}, 2'h0);
    loopClosed <= 1'b0;
    ring_period();
    chk({lineStatus[0], ringActive}, 2'h1);
    loopClosed <= 1'b1;
    ring_period();
    chk({lineStatus[0], ringActive}, 2'h0);
    ring_period();
    chk({lineStatus[0], ringActive}, 2'h2);
    loopClosed <= 1'b0;
    lfc_ctrl_model_i.frame(1'b0, 8'h01, 8, got);
    chk(lineStatus, 5'h1C);
    csModeSelect <= 1'b1;
    foreach (pats[i]) begin
      lineIn <= pats[i];
      lfc_ctrl_model_i.tick(6);
      chk({csOe, csOut}, {1'b1, pats[i][0] | pats[i][1]});
    end
    parallelStrap <= 1'b1;
    lfc_ctrl_model_i.dirSel <= 1'b1;
    lineIn <= 5'h01;
    lfc_ctrl_model_i.tick(6);
    chk(lineCmd, 8'h83);
    chk({dataOe, dataOut, csOut}, 3'b111);
    lfc_ctrl_model_i.ifaceClock <= 1'b1;
    lfc_ctrl_model_i.tick(6);
    chk(lineCmd, 8'h87);
    parallelStrap <= 1'b0;
    csModeSelect <= 1'b0;
    lfc_ctrl_model_i.ifaceClock <= 1'b0;
    lfc_ctrl_model_i.dirSel <= 1'b0;
    lfc_ctrl_model_i.tick(6);
    rst_n <= 1'b0;
    lfc_ctrl_model_i.tick(2);
    chk(lineCmd, 8'h00);
    rst_n <= 1'b1;
    lfc_ctrl_model_i.tick(3);
    chk(powerDown, 1'b1);
    wrap_up();
  end
endmodule
